/* src/one_shot_pkg.sv */
// package: register map, field positions and reset values of the
// one-shot pulse channel pair; assumes a 32-bit APB slave with byte addressing
package one_shot_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int PRS_W = 4;
  localparam int CH_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_UNIT_EN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MMODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SMODE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MRELOAD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SRELOAD = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MCOUNT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SCOUNT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_START = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STOP = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_ENABLED = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_OUT_MODE = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_OUT_LEVEL = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_TIMER_OUT = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_OUT_EN = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_PORT = 8'h40;
  // field positions
  localparam int UNIT_EN_BIT = 0;
  localparam int PRS_A_LSB = 0;
  localparam int PRS_B_LSB = 4;
  localparam int CLK_SEL_BIT = 0;
  localparam int EDGE_LSB = 1;
  localparam int PORT_OUT_MODE_BIT = 0;
  localparam int PORT_VALUE_BIT = 1;
  // trigger edge select encodings
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  // reset values
  localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // delay from trigger edge to master end event adds this many operation-clock periods to the master reload
  localparam int DELAY_EXTRA_PERIODS = 2;
  // clock rate of MCLK
  localparam int MCLK_HZ = 50_000_000;
endpackage

/* src/op_clock_tick.sv */
// operation clock tick: one-cycle enable every 2**select MCLK cycles
// assumes select is stable while channels run
`timescale 1ns/1ps
module op_clock_tick
  import one_shot_pkg::*;
#(
  parameter int SEL_W = PRS_W,
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [SEL_W-1:0] sel,
  output logic tick
);
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] mask;

  // low select bits of the divider all ones gives the tick
  assign mask = ~({DIV_W{1'b1}} << sel);
  assign tick = run && ((div & mask) == mask);

  // divider is cleared and held at zero while the unit is powered off
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end
endmodule // op_clock_tick

/* src/one_count_channel.sv */
// one-count down-counter channel: a trigger arms it, the next tick loads
// the reload value, ticks count down, a tick at zero ends the count
`timescale 1ns/1ps
module one_count_channel
  import one_shot_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic arm,
  input wire logic run,
  input wire logic tick,
  input wire logic trig,
  input wire logic [W-1:0] reload,
  output logic [W-1:0] count,
  output logic busy,
  output logic load_ev,
  output logic reach0_ev,
  output logic end_ev
);
  logic pend;

  // events of this tick
  assign load_ev = tick && run && pend;
  assign reach0_ev = tick && run && busy && (count == W'(1));
  assign end_ev = tick && run && busy && (count == '0);

  // triggers while counting are ignored; stop halts and keeps the count
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      count <= '0;
      busy <= 1'b0;
      pend <= 1'b0;
    end else if (arm) begin
      busy <= 1'b0;
      pend <= 1'b0;
    end else begin
      if (load_ev) begin
        count <= reload;
        busy <= 1'b1;
        pend <= 1'b0;
      end else if (end_ev) begin
        busy <= 1'b0;
      end else if (tick && run && busy) begin
        count <= count - 1'b1;
      end
      if (trig && run && !busy && !load_ev) begin
        pend <= 1'b1;
      end
    end
  end
endmodule // one_count_channel

/* src/one_shot_pair.sv */
// one-shot pulse channel pair: master counts the delay from a trigger edge,
// slave counts the pulse width and drives the output pin; APB register slave
// assumes inputs synchronous to MCLK and a zero-wait APB master
//
// Behaviour
// RL1: pair only with master on 0, 2, 4
// RL2: software sets slave output mode first
// RL3: unit powered off: clock stopped, writes ignored
// RL4: clock enable on: clock runs, channels stopped
// RL5: prescale register sets both operation clocks
// RL6: software writes delay and width reloads
// RL7: software starts both channels together
// RL8: start trigger bits always read zero
// RL9: start sets enabled flags, master waits edge
// RL10: valid edge loads master, counts, ends zero
// RL11: master stops at zero until next edge
// RL12: master end loads and starts slave
// RL13: output active one period after master end
// RL14: slave zero: output inactive, counter stops
// RL15: only edge select may change while running
// RL16: software keeps other settings while running
// RL17: counters readable, status register unused
// RL18: output and enable registers writable running
// RL19: stop trigger bits always read zero
// RL20: stop clears flags, counters hold values
// RL21: stop leaves output level untouched
// RL22: stopped output keeps written default level
// RL23: power off clears all unit registers
// RL24: software clears enable then sets level
// RL25: level bit selects output polarity
// RL26: one-count mode, delay reload plus two
`timescale 1ns/1ps
module one_shot_pair
  import one_shot_pkg::*;
#(
  parameter int MASTER_CH = 0
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TRIG_IN,
  output logic PULSE_OUT,
  output logic PULSE_OE,
  output logic MASTER_END,
  output logic SLAVE_END
);
  // channel bit positions within unit-wide registers
  localparam int MB = MASTER_CH;
  localparam int SB = MASTER_CH + 1;
  localparam logic PAIR_OK = (MASTER_CH == 0) || (MASTER_CH == 2) ||
                             (MASTER_CH == 4); // RL1

  typedef enum {
    PH_IDLE,
    PH_SETUP,
    PH_ACCESS
  } apb_phase_t;

  // unit power and configuration
  logic unit_en;
  logic [CH_W-1:0] prescale;
  logic [CH_W-1:0] mmode;
  logic [CH_W-1:0] smode;
  logic [CNT_W-1:0] mreload;
  logic [CNT_W-1:0] sreload;
  logic [CH_W-1:0] enabled;
  logic [CH_W-1:0] out_mode;
  logic [CH_W-1:0] out_level;
  logic [CH_W-1:0] timer_out;
  logic [CH_W-1:0] out_en;
  logic port_out_mode;
  logic port_value;
  logic trig_prev;
  apb_phase_t phase;

  // bus decode
  logic setup_cyc;
  logic access_cyc;
  logic wr_go;
  logic unit_wr;
  logic hit;
  logic [DATA_W-1:0] rd_mux;
  logic [CH_W-1:0] wbyte;

  assign setup_cyc = PSEL && !PENABLE;
  assign access_cyc = PSEL && PENABLE;
  assign PREADY = access_cyc;
  assign wr_go = access_cyc && PWRITE;
  assign unit_wr = wr_go && unit_en; // RL3
  assign wbyte = PWDATA[CH_W-1:0];

  // phase tracker for the bus; follows the master's signalling
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      phase <= PH_IDLE;
    end else begin
      case (phase)
        PH_IDLE: phase <= setup_cyc ? PH_SETUP : PH_IDLE;
        PH_SETUP: phase <= PH_ACCESS;
        PH_ACCESS: phase <= setup_cyc ? PH_SETUP : PH_IDLE;
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // write strobes per register
  logic wr_unit_en;
  logic wr_prescale;
  logic wr_mmode;
  logic wr_smode;
  logic wr_mreload;
  logic wr_sreload;
  logic wr_start;
  logic wr_stop;
  logic wr_out_mode;
  logic wr_out_level;
  logic wr_timer_out;
  logic wr_out_en;
  logic wr_port;

  assign wr_unit_en = wr_go && (PADDR == OFS_UNIT_EN);
  assign wr_port = wr_go && (PADDR == OFS_PORT);
  assign wr_prescale = unit_wr && (PADDR == OFS_PRESCALE);
  assign wr_mmode = unit_wr && (PADDR == OFS_MMODE);
  assign wr_smode = unit_wr && (PADDR == OFS_SMODE);
  assign wr_mreload = unit_wr && (PADDR == OFS_MRELOAD);
  assign wr_sreload = unit_wr && (PADDR == OFS_SRELOAD);
  assign wr_start = unit_wr && (PADDR == OFS_START);
  assign wr_stop = unit_wr && (PADDR == OFS_STOP);
  assign wr_out_mode = unit_wr && (PADDR == OFS_OUT_MODE);
  assign wr_out_level = unit_wr && (PADDR == OFS_OUT_LEVEL);
  assign wr_timer_out = unit_wr && (PADDR == OFS_TIMER_OUT); // RL18
  assign wr_out_en = unit_wr && (PADDR == OFS_OUT_EN); // RL18

  // start and stop are one-cycle triggers, never stored
  logic start_m;
  logic start_s;
  logic stop_m;
  logic stop_s;

  assign start_m = wr_start && wbyte[MB] && PAIR_OK; // RL9
  assign start_s = wr_start && wbyte[SB] && PAIR_OK; // RL9
  assign stop_m = wr_stop && wbyte[MB];
  assign stop_s = wr_stop && wbyte[SB];

  // unit power bit; only this and the port register work while off
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      unit_en <= 1'b0;
    end else if (wr_unit_en) begin
      unit_en <= PWDATA[UNIT_EN_BIT]; // RL4
    end
  end

  // port function registers lie outside the timer unit
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      port_out_mode <= 1'b0;
      port_value <= 1'b0;
    end else if (wr_port) begin
      port_out_mode <= PWDATA[PORT_OUT_MODE_BIT];
      port_value <= PWDATA[PORT_VALUE_BIT];
    end
  end

  // configuration registers; power off clears them all
  always_ff @(posedge MCLK) begin
    if (!RST_N || !unit_en) begin
      prescale <= RST_ZERO[CH_W-1:0]; // RL23
      mmode <= RST_ZERO[CH_W-1:0];
      smode <= RST_ZERO[CH_W-1:0];
      mreload <= CNT_ZERO;
      sreload <= CNT_ZERO;
      out_mode <= RST_ZERO[CH_W-1:0];
      out_level <= RST_ZERO[CH_W-1:0];
      out_en <= RST_ZERO[CH_W-1:0];
    end else begin
      if (wr_prescale) prescale <= wbyte; // RL5
      if (wr_mmode) mmode <= wbyte;
      if (wr_smode) smode <= wbyte;
      if (wr_mreload) mreload <= PWDATA[CNT_W-1:0];
      if (wr_sreload) sreload <= PWDATA[CNT_W-1:0];
      if (wr_out_mode) out_mode <= wbyte;
      if (wr_out_level) out_level <= wbyte;
      if (wr_out_en) out_en <= wbyte;
    end
  end

  // channel-enabled flags: stop beats start in the same write
  always_ff @(posedge MCLK) begin
    if (!RST_N || !unit_en) begin
      enabled <= RST_ZERO[CH_W-1:0];
    end else begin
      if (start_m) enabled[MB] <= 1'b1; // RL9
      if (start_s) enabled[SB] <= 1'b1; // RL9
      if (stop_m) enabled[MB] <= 1'b0; // RL20
      if (stop_s) enabled[SB] <= 1'b0; // RL20
    end
  end

  // two operation clocks from the prescale register
  logic tick_a;
  logic tick_b;
  logic mtick;
  logic stick;

  op_clock_tick #(.SEL_W(PRS_W), .DIV_W(CNT_W)) u_tick_a (
    .clk(MCLK),
    .rst_n(RST_N),
    .run(unit_en),
    .sel(prescale[PRS_A_LSB +: PRS_W]),
    .tick(tick_a)
  ); // RL5
  op_clock_tick #(.SEL_W(PRS_W), .DIV_W(CNT_W)) u_tick_b (
    .clk(MCLK),
    .rst_n(RST_N),
    .run(unit_en),
    .sel(prescale[PRS_B_LSB +: PRS_W]),
    .tick(tick_b)
  ); // RL5

  // mode bit selects operation clock a or b per channel
  assign mtick = mmode[CLK_SEL_BIT] ? tick_b : tick_a;
  assign stick = smode[CLK_SEL_BIT] ? tick_b : tick_a;

  // trigger edge detection with selectable edge
  logic [1:0] edge_sel;
  logic rise;
  logic fall;
  logic valid_edge;

  assign edge_sel = mmode[EDGE_LSB +: 2]; // RL15
  assign rise = TRIG_IN && !trig_prev;
  assign fall = !TRIG_IN && trig_prev;
  assign valid_edge = (edge_sel == EDGE_FALL) ? fall :
                      (edge_sel == EDGE_RISE) ? rise : (rise || fall);

  always_ff @(posedge MCLK) begin
    if (!RST_N || !unit_en) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= TRIG_IN;
    end
  end

  // master channel counts the delay
  logic [CNT_W-1:0] mcount;
  logic [CNT_W-1:0] scount;
  logic mbusy;
  logic sbusy;
  logic m_end;
  logic s_load;
  logic s_reach0;
  logic s_end;

  one_count_channel #(.W(CNT_W)) u_master (
    .clk(MCLK),
    .rst_n(RST_N),
    .clr(!unit_en),
    .arm(start_m),
    .run(enabled[MB]),
    .tick(mtick),
    .trig(valid_edge),
    .reload(mreload),
    .count(mcount),
    .busy(mbusy),
    .load_ev(),
    .reach0_ev(),
    .end_ev(m_end)
  ); // RL10 RL11 RL26

  // slave channel counts the width, triggered by the master's end
  one_count_channel #(.W(CNT_W)) u_slave (
    .clk(MCLK),
    .rst_n(RST_N),
    .clr(!unit_en),
    .arm(start_s),
    .run(enabled[SB]),
    .tick(stick),
    .trig(m_end),
    .reload(sreload),
    .count(scount),
    .busy(sbusy),
    .load_ev(s_load),
    .reach0_ev(s_reach0),
    .end_ev(s_end)
  ); // RL12 RL14 RL26

  // slave output drive needs combination mode and counting output enabled
  logic s_drive;
  logic s_act;
  logic s_inact;

  assign s_drive = out_mode[SB] && out_en[SB];
  assign s_act = s_drive && s_load && (sreload != CNT_ZERO); // RL13
  assign s_inact = s_drive && (s_reach0 || (s_load && sreload == CNT_ZERO)); // RL14

  // timer output bits; hardware change wins over a software write
  always_ff @(posedge MCLK) begin
    if (!RST_N || !unit_en) begin
      timer_out <= RST_ZERO[CH_W-1:0]; // RL23
    end else begin
      if (wr_timer_out) timer_out <= wbyte; // RL22
      if (s_act) timer_out[SB] <= !out_level[SB]; // RL25
      if (s_inact) timer_out[SB] <= out_level[SB]; // RL25
    end
  end

  // pin: timer output with port latch at 0 in output mode; off returns to port
  assign PULSE_OE = port_out_mode;
  assign PULSE_OUT = unit_en ? (timer_out[SB] | port_value) : port_value; // RL21 RL22
  assign MASTER_END = m_end;
  assign SLAVE_END = s_end;

  // read data selection; trigger and status registers read zero
  assign hit = (PADDR == OFS_UNIT_EN) || (PADDR == OFS_PRESCALE) ||
               (PADDR == OFS_MMODE) || (PADDR == OFS_SMODE) ||
               (PADDR == OFS_MRELOAD) || (PADDR == OFS_SRELOAD) ||
               (PADDR == OFS_MCOUNT) || (PADDR == OFS_SCOUNT) ||
               (PADDR == OFS_START) || (PADDR == OFS_STOP) ||
               (PADDR == OFS_ENABLED) || (PADDR == OFS_OUT_MODE) ||
               (PADDR == OFS_OUT_LEVEL) || (PADDR == OFS_TIMER_OUT) ||
               (PADDR == OFS_OUT_EN) || (PADDR == OFS_STATUS) ||
               (PADDR == OFS_PORT);

  always_comb begin
    rd_mux = RST_ZERO;
    case (PADDR)
      OFS_UNIT_EN: rd_mux[UNIT_EN_BIT] = unit_en;
      OFS_PRESCALE: rd_mux[CH_W-1:0] = prescale;
      OFS_MMODE: rd_mux[CH_W-1:0] = mmode;
      OFS_SMODE: rd_mux[CH_W-1:0] = smode;
      OFS_MRELOAD: rd_mux[CNT_W-1:0] = mreload;
      OFS_SRELOAD: rd_mux[CNT_W-1:0] = sreload;
      OFS_MCOUNT: rd_mux[CNT_W-1:0] = mcount; // RL17
      OFS_SCOUNT: rd_mux[CNT_W-1:0] = scount; // RL17
      OFS_ENABLED: rd_mux[CH_W-1:0] = enabled;
      OFS_OUT_MODE: rd_mux[CH_W-1:0] = out_mode;
      OFS_OUT_LEVEL: rd_mux[CH_W-1:0] = out_level;
      OFS_TIMER_OUT: rd_mux[CH_W-1:0] = timer_out;
      OFS_OUT_EN: rd_mux[CH_W-1:0] = out_en;
      OFS_PORT: begin
        rd_mux[PORT_OUT_MODE_BIT] = port_out_mode;
        rd_mux[PORT_VALUE_BIT] = port_value;
      end
      default: rd_mux = RST_ZERO; // RL8 RL19 RL17
    endcase
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PRDATA <= RST_ZERO;
      PSLVERR <= 1'b0;
    end else if (setup_cyc) begin
      PRDATA <= PWRITE ? RST_ZERO : rd_mux;
      PSLVERR <= !hit;
    end
  end
endmodule // one_shot_pair

/* testbench/one_shot_pair_props.sv */
// checker: bus timing and event shapes at the pins of the pulse pair
// assumes it is bound onto one_shot_pair, one MCLK domain
`timescale 1ns/1ps
module one_shot_pair_props
  import one_shot_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  input wire logic [DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TRIG_IN,
  input wire logic PULSE_OUT,
  input wire logic PULSE_OE,
  input wire logic MASTER_END,
  input wire logic SLAVE_END
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // setup phase of a read
  wire logic setup_rd = PSEL && !PENABLE && !PWRITE;
  // bus answer timing
  a_ready_zero_wait: assert property (PSEL && PENABLE |-> PREADY) else $error("no ready");
  a_ready_idle: assert property (!PSEL |-> !PREADY) else $error("ready while idle");
  a_rdata_stands: assert property ($changed(PRDATA) |-> $past(PSEL && !PENABLE))
    else $error("read data moved outside setup");
  a_err_unmapped: assert property (PSEL && !PENABLE && PADDR > OFS_PORT |=> PSLVERR)
    else $error("unmapped place not refused");
  a_err_mapped: assert property (PSEL && !PENABLE && PADDR <= OFS_PORT && PADDR[1:0] == 2'h0
    |=> !PSLVERR) else $error("mapped place refused");
  // self-clearing trigger bits and unused status
  a_trig_read_zero: assert property (setup_rd && (PADDR == OFS_START || PADDR == OFS_STOP)
    |=> PRDATA == RST_ZERO) else $error("trigger bits read nonzero");
  a_status_zero: assert property (setup_rd && PADDR == OFS_STATUS |=> PRDATA == RST_ZERO)
    else $error("status reads nonzero");
  // count-end events are single pulses
  a_mend_single: assert property (MASTER_END |=> !MASTER_END) else $error("master end long");
  a_send_single: assert property (SLAVE_END |=> !SLAVE_END) else $error("slave end long");
  // pin enable moves only by a register write
  a_oe_by_write: assert property ($changed(PULSE_OE) |-> $past(PSEL && PENABLE && PWRITE))
    else $error("pin enable moved without write");
  // reset clears pin and events
  a_rst_quiet: assert property (disable iff (1'b0) !RST_N
    |=> !PULSE_OE && !PULSE_OUT && !MASTER_END && !SLAVE_END) else $error("reset not quiet");
endmodule // one_shot_pair_props

bind one_shot_pair one_shot_pair_props i_one_shot_pair_props (.MCLK(MCLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG_IN(TRIG_IN),
  .PULSE_OUT(PULSE_OUT), .PULSE_OE(PULSE_OE), .MASTER_END(MASTER_END), .SLAVE_END(SLAVE_END));

/* testbench/trig_pin_model.sv */
// far side: trigger source and the output pin with its pull-up
// assumes fire is changed by the bench right after a rising clock edge
`timescale 1ns/1ps
module trig_pin_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic trig,
  output logic pin
);
  // trigger follows the request one cycle later
  initial trig = 1'b0;
  always @(posedge clk) trig <= fire;
  // a released pin floats to the pull-up
  assign pin = pin_oe ? pin_out : 1'b1;
endmodule // trig_pin_model

/* testbench/one_shot_pair_bench.sv */
// testbench: drives the pulse pair over the bus, checks delay, width and registers
// assumes one_shot_pair with master on channel 0 and the bound checker
`timescale 1ns/1ps
module one_shot_pair_bench;
  import one_shot_pkg::*;
  localparam int RM = 4;
  localparam int RS = 6;
  logic MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TRIG_IN, fire, pin;
  logic PULSE_OUT, PULSE_OE, MASTER_END, SLAVE_END;
  logic [ADDR_W-1:0] PADDR;
  logic [DATA_W-1:0] PWDATA, PRDATA;
  int err_count = 0;
  int n_tests = 0;

  one_shot_pair #(.MASTER_CH(0)) i_one_shot_pair (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG_IN(TRIG_IN), .PULSE_OUT(PULSE_OUT),
    .PULSE_OE(PULSE_OE), .MASTER_END(MASTER_END), .SLAVE_END(SLAVE_END));
  trig_pin_model i_trig_pin_model (.clk(MCLK), .fire(fire), .pin_out(PULSE_OUT),
    .pin_oe(PULSE_OE), .trig(TRIG_IN), .pin(pin));

  // 50 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  task automatic results();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus transfer, entered right after a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q, output logic e);
    int k;
    k = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'b1 && k < 16);
    if (PREADY !== 1'b1) begin
      err_count++;
      results();
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    logic e;
    apb(1'b0, a, RST_ZERO, q, e);
    chk(q, exp);
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? MASTER_END : pin;
  endfunction

  // counts settled cycles until the watched signal shows v
  task automatic cnt(input int w, input logic v, output int n);
    n = 0;
    do begin
      @(negedge MCLK);
      n++;
    end while (pick(w) !== v && n < 2000);
    if (n >= 2000) begin
      err_count++;
      results();
    end
  endtask

  // sets up both channels and starts them
  task automatic t_cfg(input logic lvl, input int prs);
    wr(OFS_PRESCALE, DATA_W'(prs));
    wr(OFS_MMODE, 32'h0000_0002);
    wr(OFS_SMODE, RST_ZERO);
    wr(OFS_MRELOAD, DATA_W'(RM));
    wr(OFS_SRELOAD, DATA_W'(RS));
    wr(OFS_OUT_MODE, 32'h0000_0002);
    wr(OFS_OUT_LEVEL, {30'h0, lvl, 1'b0});
    wr(OFS_TIMER_OUT, {30'h0, lvl, 1'b0});
    wr(OFS_OUT_EN, 32'h0000_0002);
    wr(OFS_PORT, 32'h0000_0001);
    chk(DATA_W'(pin), DATA_W'(lvl));
    chk(DATA_W'(PULSE_OE), 32'h0000_0001);
    wr(OFS_START, 32'h0000_0003);
    rd(OFS_START, RST_ZERO);
    rd(OFS_ENABLED, 32'h0000_0003);
  endtask

  // one trigger edge, then delay measured at the master end event and pulse width measured at the pin
  task automatic t_pulse(input logic lvl, input int per);
    int n;
    @(posedge MCLK);
    fire <= 1'b1;
    @(posedge MCLK);
    fire <= 1'b0;
    // first settled sample with the trigger high is where the delay starts
    @(negedge MCLK);
    cnt(0, 1'b1, n);
    if (per == 1) begin
      chk(DATA_W'(n), DATA_W'(RM + 2));
    end
    // end pulse is taken mid-pulse at a falling edge, output is seen active two samples on
    cnt(1, ~lvl, n);
    if (per == 1) begin
      chk(DATA_W'(n), 32'h0000_0002);
    end
    cnt(1, lvl, n);
    chk(DATA_W'(n), DATA_W'(RS * per));
    // slave end pulse stands in the cycle the output turns inactive
    if (per == 1) begin
      chk(DATA_W'(SLAVE_END), 32'h0000_0001);
    end
    @(posedge MCLK);
  endtask

  // stop in mid-pulse: slave count and level hold
  task automatic t_stop();
    logic [DATA_W-1:0] q1, q2;
    logic e;
    int n;
    @(posedge MCLK);
    fire <= 1'b1;
    @(posedge MCLK);
    fire <= 1'b0;
    cnt(0, 1'b1, n);
    cnt(1, 1'b1, n);
    @(posedge MCLK);
    wr(OFS_STOP, 32'h0000_0003);
    rd(OFS_STOP, RST_ZERO);
    rd(OFS_ENABLED, RST_ZERO);
    apb(1'b0, OFS_SCOUNT, RST_ZERO, q1, e);
    repeat (5) @(posedge MCLK);
    apb(1'b0, OFS_SCOUNT, RST_ZERO, q2, e);
    chk(q2, q1);
    chk(DATA_W'(q1 == RST_ZERO), RST_ZERO);
    chk(DATA_W'(pin), 32'h0000_0001);
    wr(OFS_OUT_EN, RST_ZERO);
    wr(OFS_TIMER_OUT, RST_ZERO);
    chk(DATA_W'(pin), RST_ZERO);
  endtask

  // main sequence
  initial begin
    logic [DATA_W-1:0] q;
    logic e;
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = '0;
    fire = 1'b0;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    wr(OFS_MRELOAD, 32'h0000_0005);
    rd(OFS_MRELOAD, RST_ZERO);
    apb(1'b0, 8'h80, RST_ZERO, q, e);
    chk(DATA_W'(e), 32'h0000_0001);
    chk(q, RST_ZERO);
    wr(OFS_UNIT_EN, 32'h0000_0001);
    rd(OFS_ENABLED, RST_ZERO);
    wr(OFS_MRELOAD, 32'h0000_0005);
    rd(OFS_MRELOAD, 32'h0000_0005);
    t_cfg(1'b0, 0);
    t_pulse(1'b0, 1);
    rd(OFS_MCOUNT, RST_ZERO);
    rd(OFS_SCOUNT, RST_ZERO);
    rd(OFS_STATUS, RST_ZERO);
    wr(OFS_OUT_EN, RST_ZERO);
    rd(OFS_OUT_EN, RST_ZERO);
    wr(OFS_OUT_EN, 32'h0000_0002);
    wr(OFS_MMODE, 32'h0000_0004);
    t_pulse(1'b0, 1);
    t_stop();
    t_cfg(1'b1, 1);
    t_pulse(1'b1, 2);
    wr(OFS_UNIT_EN, RST_ZERO);
    wr(OFS_UNIT_EN, 32'h0000_0001);
    rd(OFS_MRELOAD, RST_ZERO);
    rd(OFS_TIMER_OUT, RST_ZERO);
    results();
  end
endmodule // one_shot_pair_bench
